// ===== rtc_alarm_pkg.sv
// constants and types for the alarm match unit and its timekeeping registers
package rtc_alarm_pkg;

	// -----------------------------------------------------------------
	// timing
	// -----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int SECOND_NS = 1_000_000_000;
	localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
	localparam int DIV_W = 24;

	// -----------------------------------------------------------------
	// register map
	// -----------------------------------------------------------------
	localparam logic [7:0] ADDR_SEC = 8'h00;
	localparam logic [7:0] ADDR_MIN = 8'h01;
	localparam logic [7:0] ADDR_HOUR = 8'h02;
	localparam logic [7:0] ADDR_WKDAY = 8'h03;
	localparam logic [7:0] ADDR_DATE = 8'h04;
	localparam logic [7:0] ADDR_MTH = 8'h05;
	localparam logic [7:0] ADDR_YEAR = 8'h06;
	localparam logic [7:0] ADDR_CTRL = 8'h07;
	localparam logic [7:0] ADDR_ALM0 = 8'h0A;
	localparam logic [7:0] ADDR_ALM1 = 8'h11;
	localparam logic [7:0] OFS_SEC = 8'h00;
	localparam logic [7:0] OFS_MIN = 8'h01;
	localparam logic [7:0] OFS_HOUR = 8'h02;
	localparam logic [7:0] OFS_CFG = 8'h03;
	localparam logic [7:0] OFS_DATE = 8'h04;
	localparam logic [7:0] OFS_MTH = 8'h05;

	// -----------------------------------------------------------------
	// field positions and reset values
	// -----------------------------------------------------------------
	localparam int START_BIT = 7;
	localparam int OSCRUN_BIT = 5;
	localparam int VBATEN_BIT = 3;
	localparam int LEAP_BIT = 5;
	localparam int FMT_BIT = 6;
	localparam int PM_BIT = 5;
	localparam int CTRL_OUT_BIT = 7;
	localparam int CTRL_SQUARE_WAVE_OUTPUT_ENABLE_BIT = 6;
	localparam int CTRL_EN_LO = 4;
	localparam int POL_BIT = 7;
	localparam int MSK_LO = 4;
	localparam int FLAG_BIT = 3;
	localparam logic [7:0] YEAR_RST = 8'h01;
	localparam logic [5:0] DATE_RST = 6'h01;
	localparam logic [4:0] MTH_RST = 5'h01;
	localparam logic [2:0] WKDAY_RST = 3'h1;
	localparam logic CTRL_OUT_RST = 1'b1;

	typedef enum logic [2:0] {
		MSK_SEC = 3'b000,
		MSK_MIN = 3'b001,
		MSK_HOUR = 3'b010,
		MSK_WKDAY = 3'b011,
		MSK_DATE = 3'b100,
		MSK_ALL = 3'b111
	} match_sel_type;

endpackage

// ===== rtc_alarm_match_unit.sv
// dual alarm match unit with bcd timekeeping registers and multi-function pin
`timescale 1ns/1ps
`default_nettype none

module rtc_alarm_match_unit
	import rtc_alarm_pkg::*;
#(
	parameter int unsigned SECOND_CYCLES_P = SECOND_CYCLES
)
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic regWrEn,
	input wire logic [7:0] regWrData,
	input wire logic regRdEn,
	output logic [7:0] regRdData,
	// supply state
	input wire logic onBackup,
	// multi-function pin, open drain
	output logic mfpO,
	output logic mfpOe
);

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	typedef struct packed {
		logic [DIV_W-1:0] div;
		logic [7:0] sec;
		logic [6:0] min;
		logic [6:0] hour;
		logic vbaten;
		logic [2:0] wkday;
		logic [5:0] date;
		logic [4:0] mth;
		logic [7:0] year;
		logic outBit;
		logic square_wave_output_enable;
		logic [1:0] en;
		logic pol;
		logic [1:0][6:0] aSec;
		logic [1:0][6:0] aMin;
		logic [1:0][6:0] aHour;
		logic [1:0][2:0] aMsk;
		logic [1:0][2:0] aWk;
		logic [1:0][5:0] aDate;
		logic [1:0][4:0] aMth;
		logic [1:0] flag;
		logic [7:0] rdData;
		logic mfpLevel;
	} state_type;

	state_type q;
	state_type d;
	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	function automatic logic [7:0] incBcd(input logic [7:0] v);
		if (v[3:0] == 4'h9)
			incBcd = {v[7:4] + 4'h1, 4'h0};
		else
			incBcd = {v[7:4], v[3:0] + 4'h1};
	endfunction
	function automatic logic isLeap(input logic [7:0] y);
		if (y[4])
			isLeap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
		else
			isLeap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
	endfunction
	function automatic logic [5:0] lastDay(input logic [4:0] m, input logic leap);
		case (m)
			5'h02: lastDay = leap ? 6'h29 : 6'h28;
			5'h04, 5'h06, 5'h09, 5'h11: lastDay = 6'h30;
			default: lastDay = 6'h31;
		endcase
	endfunction
	function automatic logic [7:0] almAddr(input int i, input logic [7:0] ofs);
		almAddr = ((i == 0) ? ADDR_ALM0 : ADDR_ALM1) + ofs;
	endfunction

	logic wr;
	logic tick;
	logic halfPhase;
	logic leap;
	logic alarmMode;
	logic asserted;
	logic [1:0] setEvt;
	logic [1:0] cfgClr;

	// host writes are lost without main power; timekeeping and alarms carry on
	assign wr = regWrEn && !onBackup;
	assign tick = q.div == DIV_W'(SECOND_CYCLES_P - 1);
	assign halfPhase = q.div < DIV_W'(SECOND_CYCLES_P / 2);
	assign leap = isLeap(q.year);

	// -----------------------------------------------------------------
	// alarm comparison
	// -----------------------------------------------------------------
	for (genvar g = 0; g < 2; g++)
	begin : alm
		logic m;
		always_comb
		begin
			case (match_sel_type'(q.aMsk[g]))
				MSK_SEC: m = q.aSec[g] == q.sec[6:0];
				MSK_MIN: m = q.aMin[g] == q.min;
				MSK_HOUR: m = q.aHour[g] == q.hour;
				MSK_WKDAY: m = q.aWk[g] == q.wkday;
				MSK_DATE: m = q.aDate[g] == q.date;
				MSK_ALL: m = (q.aSec[g] == q.sec[6:0]) && (q.aMin[g] == q.min) && (q.aHour[g] == q.hour)
					&& (q.aWk[g] == q.wkday) && (q.aDate[g] == q.date) && (q.aMth[g] == q.mth);
				default: m = 1'b0;
			endcase
		end
		// level compare on live registers, so ticks and writes both count
		assign setEvt[g] = q.en[g] && m;
		assign cfgClr[g] = wr && (regAddr == almAddr(g, OFS_CFG)) && !regWrData[FLAG_BIT];
	end

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb
	begin
		logic [7:0] t;
		logic dayCarry;
		t = 8'h00;
		dayCarry = 1'b0;
		d = q;
		// counting
		if (!q.sec[START_BIT] || tick)
			d.div = '0;
		else
			d.div = q.div + DIV_W'(1);
		if (tick && q.sec[START_BIT])
		begin
			if (q.sec[6:0] != 7'h59)
			begin
				t = incBcd({1'b0, q.sec[6:0]});
				d.sec[6:0] = t[6:0];
			end
			else
			begin
				d.sec[6:0] = 7'h00;
				if (q.min != 7'h59)
				begin
					t = incBcd({1'b0, q.min});
					d.min = t[6:0];
				end
				else
				begin
					d.min = 7'h00;
					if (q.hour[FMT_BIT])
					begin
						if (q.hour[4:0] == 5'h12)
							d.hour[4:0] = 5'h01;
						else if (q.hour[4:0] == 5'h11)
						begin
							d.hour[4:0] = 5'h12;
							d.hour[PM_BIT] = !q.hour[PM_BIT];
							dayCarry = q.hour[PM_BIT];
						end
						else
						begin
							t = incBcd({3'b000, q.hour[4:0]});
							d.hour[4:0] = t[4:0];
						end
					end
					else if (q.hour[5:0] == 6'h23)
					begin
						d.hour[5:0] = 6'h00;
						dayCarry = 1'b1;
					end
					else
					begin
						t = incBcd({2'b00, q.hour[5:0]});
						d.hour[5:0] = t[5:0];
					end
				end
			end
		end
		if (dayCarry)
		begin
			d.wkday = (q.wkday == 3'h7) ? 3'h1 : q.wkday + 3'h1;
			if (q.date != lastDay(q.mth, leap))
			begin
				t = incBcd({2'b00, q.date});
				d.date = t[5:0];
			end
			else
			begin
				d.date = 6'h01;
				if (q.mth != 5'h12)
				begin
					t = incBcd({3'b000, q.mth});
					d.mth = t[4:0];
				end
				else
				begin
					d.mth = 5'h01;
					d.year = (q.year == 8'h99) ? 8'h00 : incBcd(q.year);
				end
			end
		end
		// host writes win over counting in the same cycle
		if (wr)
		begin
			case (regAddr)
				ADDR_SEC: d.sec = regWrData;
				ADDR_MIN: d.min = regWrData[6:0];
				ADDR_HOUR: d.hour = regWrData[6:0];
				ADDR_WKDAY:
				begin
					d.vbaten = regWrData[VBATEN_BIT];
					d.wkday = regWrData[2:0];
				end
				ADDR_DATE: d.date = regWrData[5:0];
				ADDR_MTH: d.mth = regWrData[4:0];
				ADDR_YEAR: d.year = regWrData;
				ADDR_CTRL:
				begin
					d.outBit = regWrData[CTRL_OUT_BIT];
					d.square_wave_output_enable = regWrData[CTRL_SQUARE_WAVE_OUTPUT_ENABLE_BIT];
					d.en = regWrData[CTRL_EN_LO+1:CTRL_EN_LO];
				end
				default: d.year = d.year;
			endcase
			for (int i = 0; i < 2; i++)
			begin
				if (regAddr == almAddr(i, OFS_SEC))
					d.aSec[i] = regWrData[6:0];
				if (regAddr == almAddr(i, OFS_MIN))
					d.aMin[i] = regWrData[6:0];
				if (regAddr == almAddr(i, OFS_HOUR))
					d.aHour[i] = regWrData[6:0];
				if (regAddr == almAddr(i, OFS_CFG))
				begin
					d.aMsk[i] = regWrData[MSK_LO+2:MSK_LO];
					d.aWk[i] = regWrData[2:0];
					if (i == 0)
						d.pol = regWrData[POL_BIT];
				end
				if (regAddr == almAddr(i, OFS_DATE))
					d.aDate[i] = regWrData[5:0];
				if (regAddr == almAddr(i, OFS_MTH))
					d.aMth[i] = regWrData[4:0];
			end
		end
		// software may only clear; a match in the same cycle sets again
		for (int i = 0; i < 2; i++)
			d.flag[i] = (q.flag[i] && !cfgClr[i]) || setEvt[i];
		// read data, unused bits zero
		if (regRdEn)
		begin
			case (regAddr)
				ADDR_SEC: d.rdData = q.sec;
				ADDR_MIN: d.rdData = {1'b0, q.min};
				ADDR_HOUR: d.rdData = {1'b0, q.hour};
				ADDR_WKDAY: d.rdData = {2'b00, q.sec[START_BIT], 1'b0, q.vbaten, q.wkday};
				ADDR_DATE: d.rdData = {2'b00, q.date};
				ADDR_MTH: d.rdData = {2'b00, leap, q.mth};
				ADDR_YEAR: d.rdData = q.year;
				ADDR_CTRL: d.rdData = {q.outBit, q.square_wave_output_enable, q.en, 4'h0};
				default: d.rdData = 8'h00;
			endcase
			for (int i = 0; i < 2; i++)
			begin
				if (regAddr == almAddr(i, OFS_SEC))
					d.rdData = {1'b0, q.aSec[i]};
				if (regAddr == almAddr(i, OFS_MIN))
					d.rdData = {1'b0, q.aMin[i]};
				if (regAddr == almAddr(i, OFS_HOUR))
					d.rdData = {1'b0, q.aHour[i]};
				if (regAddr == almAddr(i, OFS_CFG))
					d.rdData = {(i == 0) ? q.pol : 1'b0, q.aMsk[i], q.flag[i], q.aWk[i]};
				if (regAddr == almAddr(i, OFS_DATE))
					d.rdData = {2'b00, q.aDate[i]};
				if (regAddr == almAddr(i, OFS_MTH))
					d.rdData = {3'b000, q.aMth[i]};
			end
		end
		// pin level
		if (alarmMode)
			d.mfpLevel = q.pol ? asserted : !asserted;
		else
			d.mfpLevel = q.square_wave_output_enable ? halfPhase : q.outBit;
	end

	assign alarmMode = (|q.en) && !q.square_wave_output_enable;
	assign asserted = |(q.flag & q.en);

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			q <= '0;
			q.year <= YEAR_RST;
			q.date <= DATE_RST;
			q.mth <= MTH_RST;
			q.wkday <= WKDAY_RST;
			q.outBit <= CTRL_OUT_RST;
			q.mfpLevel <= CTRL_OUT_RST;
		end
		else
			q <= d;
	end

	// -----------------------------------------------------------------
	// outputs
	// -----------------------------------------------------------------
	// open drain: only ever pulls low, released level comes from the pull-up
	assign mfpO = 1'b0;
	assign mfpOe = !q.mfpLevel;
	assign regRdData = q.rdData;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	AST_FLAG_SET: assert property (setEvt[0] |=> q.flag[0])
		else $error("alarm0 match did not set its flag");
	AST_FLAG_STICKY: assert property ((q.flag[1] && !cfgClr[1]) |=> q.flag[1])
		else $error("alarm1 flag dropped without a clear");
	AST_FLAG_AGAIN: assert property ((cfgClr[0] && setEvt[0]) |=> q.flag[0])
		else $error("clear during match did not set flag again");
	AST_DISABLED_QUIET: assert property ((!q.en[1] && !q.flag[1]) |=> !q.flag[1])
		else $error("disabled alarm1 raised its flag");
	AST_RESERVED_MASK: assert property ((q.aMsk[0] inside {3'b101, 3'b110} && !q.flag[0]) |=> !q.flag[0])
		else $error("reserved mask produced a match");
	AST_PIN_ALARM: assert property ((alarmMode && asserted) |=> (mfpOe == !$past(q.pol)))
		else $error("pin not at active alarm level");
	AST_PIN_IDLE: assert property ((alarmMode && !asserted && !q.pol) |=> !mfpOe)
		else $error("pin asserted with no alarm event");
	AST_SEC_WRAP: assert property ((tick && q.sec[START_BIT] && q.sec[6:0] == 7'h59 && !regWrEn)
		|=> q.sec[6:0] == 7'h00)
		else $error("seconds did not wrap from 59 to 00");
	AST_ALM1_SEC_READ: assert property ((regRdEn && regAddr == ADDR_ALM1)
		|=> regRdData == {1'b0, $past(q.aSec[1])})
		else $error("alarm1 seconds read wrong data");
	AST_ALM0_SEC_TOP: assert property ((regRdEn && regAddr == ADDR_ALM0) |=> !regRdData[7])
		else $error("alarm0 seconds bit 7 not zero");

endmodule

`default_nettype wire

// ===== rtc_host_model.sv
// host bus master model driving the alarm unit register port
`timescale 1ns/1ps
`default_nettype none

module rtc_host_model
	import rtc_alarm_pkg::*;
(
	// clock
	input wire logic clk,
	// register port
	output var logic [7:0] regAddr,
	output var logic regWrEn,
	output var logic [7:0] regWrData,
	output var logic regRdEn
);
	// ----------------------------------------
	// bus cycles
	// ----------------------------------------
	initial
	begin
		regAddr = 8'h00;
		regWrEn = 1'b0;
		regWrData = 8'h00;
		regRdEn = 1'b0;
	end

	// callers may hand over non-bcd upper bits, such as 8'hA5 to minutes; the unit drops what it does not store
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(posedge clk);
		#1;
		regWrEn = 1'b0;
		// released lines show the inverse so stale values never pass
		regAddr = ~a;
		regWrData = ~d;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		#1;
		regAddr = a;
		regRdEn = 1'b1;
		@(posedge clk);
		#1;
		regRdEn = 1'b0;
		regAddr = ~a;
	endtask

	// time and start, then mask, polarity (alarm0 only) and flag clear in cfg, then match, then enable
	task automatic setup(input logic [7:0] base, input logic [7:0] now, input logic [7:0] cfg,
		input logic [7:0] match, input logic [7:0] ctrl);
		wr(ADDR_SEC, now);
		wr(base + OFS_CFG, cfg);
		wr(base + OFS_SEC, match);
		wr(ADDR_CTRL, ctrl);
	endtask
endmodule

`default_nettype wire

// ===== rtc_alarm_match_unit_tb.sv
// self-checking testbench for the alarm match unit
`timescale 1ns/1ps
`default_nettype none

module rtc_alarm_match_unit_tb
	import rtc_alarm_pkg::*;
;
	// ----------------------------------------
	// signals and instances
	// ----------------------------------------
	localparam int SEC_P = 20;
	logic clk, sys_rst, onBackup, regWrEn, regRdEn, mfpO, mfpOe, hit;
	logic rdPend = 1'b0;
	logic [7:0] regAddr, regWrData, regRdData, yr, cfg;
	logic [2:0] wd;
	logic [7:0] expQ[$];
	int errorCnt = 0;
	int testsRun = 0;

	rtc_alarm_match_unit #(.SECOND_CYCLES_P(SEC_P)) rtc_alarm_match_unit_i (.clk(clk), .sys_rst(sys_rst),
		.regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
		.regRdData(regRdData), .onBackup(onBackup), .mfpO(mfpO), .mfpOe(mfpOe));
	rtc_host_model rtc_host_model_i (.clk(clk), .regAddr(regAddr), .regWrEn(regWrEn),
		.regWrData(regWrData), .regRdEn(regRdEn));

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ----------------------------------------
	// checking
	// ----------------------------------------
	task automatic tallyAndFinish();
		if (errorCnt == 0 && testsRun > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp);
		testsRun++;
		if (got !== exp)
		begin
			errorCnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmpBit(input logic got, input logic exp);
		testsRun++;
		if (got !== exp)
		begin
			errorCnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// read data is valid the cycle after the strobe edge
	always @(posedge clk)
	begin
		if (rdPend)
			cmpByte(regRdData, expQ.pop_front());
		rdPend <= regRdEn;
	end

	task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
		expQ.push_back(exp);
		rtc_host_model_i.rd(a);
	endtask

	task automatic waitPin(input logic exp);
		int n;
		n = 0;
		while (mfpOe !== exp && n < 100)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		cmpBit(mfpOe, exp);
		if (n >= 100)
			tallyAndFinish();
	endtask

	function automatic logic [7:0] pick(input bit on, input logic [7:0] v);
		return on ? v : v + 8'h01;
	endfunction

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial
	begin
		sys_rst = 1'b1;
		onBackup = 1'b0;
		void'($urandom(32'hacd3));
		repeat (20) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		rdChk(ADDR_YEAR, 8'h01);
		rdChk(ADDR_ALM0, 8'h00);
		rdChk(ADDR_ALM1, 8'h00);
		yr = {4'($urandom_range(9)), 4'($urandom_range(9))};
		rtc_host_model_i.wr(ADDR_YEAR, yr);
		rdChk(ADDR_YEAR, yr);
		rtc_host_model_i.wr(ADDR_ALM1, 8'hD9);
		rdChk(ADDR_ALM1, 8'h59);
		rtc_host_model_i.wr(ADDR_MIN, 8'hA5);
		rdChk(ADDR_MIN, 8'h25);
		rdChk(8'h08, 8'h00);
		// oscillator held stopped so the compared time stays put
		rtc_host_model_i.wr(ADDR_SEC, 8'h05);
		rtc_host_model_i.wr(ADDR_MIN, 8'h10);
		rtc_host_model_i.wr(ADDR_HOUR, 8'h03);
		rtc_host_model_i.wr(ADDR_WKDAY, 8'h02);
		rtc_host_model_i.wr(ADDR_DATE, 8'h15);
		rtc_host_model_i.wr(ADDR_MTH, 8'h06);
		rtc_host_model_i.wr(ADDR_CTRL, 8'h10);
		for (int m = 0; m < 8; m++)
		begin
			rtc_host_model_i.wr(ADDR_ALM0 + OFS_SEC, pick(m == 0 || m == 7, 8'h05));
			rtc_host_model_i.wr(ADDR_ALM0 + OFS_MIN, pick(m == 1 || m == 7, 8'h10));
			rtc_host_model_i.wr(ADDR_ALM0 + OFS_HOUR, pick(m == 2 || m == 7, 8'h03));
			rtc_host_model_i.wr(ADDR_ALM0 + OFS_DATE, pick(m == 4 || m == 7, 8'h15));
			rtc_host_model_i.wr(ADDR_ALM0 + OFS_MTH, pick(m == 7, 8'h06));
			wd = (m == 3 || m == 7) ? 3'h2 : 3'h3;
			hit = !(m == 5 || m == 6);
			rtc_host_model_i.wr(ADDR_ALM0 + OFS_CFG, {1'b0, 3'(m), 1'b0, wd});
			repeat (3) @(posedge clk);
			rdChk(ADDR_ALM0 + OFS_CFG, {1'b0, 3'(m), hit, wd});
		end
		waitPin(1'b1);
		rtc_host_model_i.wr(ADDR_ALM0 + OFS_CFG, 8'hF2);
		waitPin(1'b0);
		rtc_host_model_i.wr(ADDR_ALM1 + OFS_SEC, 8'h05);
		rtc_host_model_i.wr(ADDR_ALM1 + OFS_CFG, 8'h02);
		repeat (3) @(posedge clk);
		rdChk(ADDR_ALM1 + OFS_CFG, 8'h02);
		rtc_host_model_i.wr(ADDR_CTRL, 8'h20);
		rtc_host_model_i.wr(ADDR_ALM0 + OFS_CFG, 8'h72);
		repeat (3) @(posedge clk);
		rdChk(ADDR_ALM1 + OFS_CFG, 8'h0A);
		rdChk(ADDR_ALM0 + OFS_CFG, 8'h72);
		// counting from 09 must carry in bcd to reach the 10 match
		cfg = 8'h01;
		rtc_host_model_i.setup(ADDR_ALM0, 8'h89, cfg, 8'h10, 8'h10);
		onBackup = 1'b1;
		rtc_host_model_i.wr(ADDR_YEAR, 8'h00);
		waitPin(1'b1);
		rdChk(ADDR_YEAR, yr);
		repeat (45) @(posedge clk);
		rdChk(ADDR_ALM0 + OFS_CFG, 8'h09);
		cmpBit(mfpOe, 1'b1);
		onBackup = 1'b0;
		rtc_host_model_i.wr(ADDR_ALM0 + OFS_CFG, cfg);
		waitPin(1'b0);
		cmpBit(mfpO, 1'b0);
		// stop first so the divider restarts from zero, then run from 59 into a wrap and minute carry
		rtc_host_model_i.wr(ADDR_SEC, 8'h59);
		rtc_host_model_i.wr(ADDR_SEC, 8'hD9);
		repeat (22) @(posedge clk);
		rdChk(ADDR_SEC, 8'h80);
		rdChk(ADDR_MIN, 8'h11);
		// square wave takes the pin away from the alarm, so it toggles with no match
		rtc_host_model_i.wr(ADDR_CTRL, 8'h50);
		waitPin(1'b1);
		waitPin(1'b0);
		repeat (3) @(posedge clk);
		tallyAndFinish();
	end
endmodule

`default_nettype wire
